// *** hw/bsc_pkg.sv ***
// constants, operation codes and request carrier for the branch, skip and compare unit
// assumes a decoder upstream that presents one decoded operation with its operands already read
package bsc_pkg;
   localparam int PC_W = 16;
   localparam int K_W = 7;
   localparam int CYC_W = 3;
   // flag register bit positions
   localparam logic [2:0] FLAG_C = 3'h0;
   localparam logic [2:0] FLAG_Z = 3'h1;
   localparam logic [2:0] FLAG_N = 3'h2;
   localparam logic [2:0] FLAG_V = 3'h3;
   localparam logic [2:0] FLAG_S = 3'h4;
   localparam logic [2:0] FLAG_H = 3'h5;
   localparam logic [2:0] FLAG_T = 3'h6;
   localparam logic [2:0] FLAG_I = 3'h7;
   // cycle counts
   localparam logic [CYC_W-1:0] CYC_SHORT = 3'h1;
   localparam logic [CYC_W-1:0] CYC_TAKEN = 3'h2;
   localparam logic [CYC_W-1:0] CYC_SKIP_LONG = 3'h3;
   localparam logic [CYC_W-1:0] CYC_PTR_CALL = 3'h3;
   localparam logic [CYC_W-1:0] CYC_CALL_RET = 3'h4;
   // pc steps
   localparam logic [PC_W-1:0] PC_STEP_ONE = 16'h0001;
   localparam logic [PC_W-1:0] PC_STEP_TWO = 16'h0002;
   localparam logic [PC_W-1:0] PC_STEP_THREE = 16'h0003;
   localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
   localparam logic [7:0] FLAGS_RESET = 8'h00;

   typedef enum logic [4:0] {
      OP_POINTER_SUBROUTINE_JUMP = 5'h00,
      OP_DIRECT_SUBROUTINE_JUMP = 5'h01,
      OP_SUBROUTINE_EXIT = 5'h02,
      OP_INTERRUPT_EXIT = 5'h03,
      OP_COMPARE_SKIP_EQUAL = 5'h04,
      OP_COMPARE_REGISTERS = 5'h05,
      OP_COMPARE_WITH_BORROW = 5'h06,
      OP_COMPARE_IMMEDIATE = 5'h07,
      OP_SKIP_REG_BIT_CLEAR = 5'h08,
      OP_SKIP_REG_BIT_SET = 5'h09,
      OP_SKIP_IO_BIT_CLEAR = 5'h0a,
      OP_SKIP_IO_BIT_SET = 5'h0b,
      OP_BRANCH_FLAG_SET = 5'h0c,
      OP_BRANCH_FLAG_CLEAR = 5'h0d,
      OP_BRANCH_EQUAL = 5'h0e,
      OP_BRANCH_NOT_EQUAL = 5'h0f,
      OP_BRANCH_CARRY_SET = 5'h10,
      OP_BRANCH_CARRY_CLEAR = 5'h11,
      OP_BRANCH_SAME_OR_HIGHER = 5'h12,
      OP_BRANCH_UNSIGNED_LOWER = 5'h13,
      OP_BRANCH_NEGATIVE = 5'h14,
      OP_BRANCH_POSITIVE = 5'h15,
      OP_BRANCH_SIGNED_GE = 5'h16,
      OP_BRANCH_SIGNED_LESS = 5'h17,
      OP_BRANCH_HALF_CARRY_SET = 5'h18,
      OP_BRANCH_HALF_CARRY_CLEAR = 5'h19,
      OP_BRANCH_TRANSFER_SET = 5'h1a,
      OP_BRANCH_TRANSFER_CLEAR = 5'h1b,
      OP_BRANCH_OVERFLOW_SET = 5'h1c,
      OP_BRANCH_OVERFLOW_CLEAR = 5'h1d
   } bsc_op_t;

   typedef struct packed {
      logic valid;
      bsc_op_t op;
      logic [PC_W-1:0] pc;
      logic [7:0] rd_val;
      logic [7:0] rr_val;
      logic [7:0] imm;
      logic [2:0] bit_sel;
      logic [7:0] io_val;
      logic [2:0] flag_sel;
      logic [K_W-1:0] offset;
      logic [PC_W-1:0] target;
      logic next_two_word;
   } bsc_req_t;

   typedef enum logic [1:0] {
      ST_READY = 2'b01,
      ST_BUSY = 2'b10
   } bsc_state_t;
endpackage

// *** hw/bsc_unit.sv ***
// program-flow execution: calls, returns, compares, skips and flag branches
// assumes the core presents pc, flags, pointer and stack top on the same clock and applies
// the pc, flag and stack results on the cycle the done pulse shows
`timescale 1ns/1ps
module bsc_unit (
   input wire logic clock,
   input wire logic srst,
   input bsc_pkg::bsc_req_t req,
   input wire logic [7:0] flags_in,
   input wire logic [15:0] zptr,
   input wire logic [15:0] stack_top,
   output logic req_ready_r,
   output logic done_r,
   output logic pc_wr_r,
   output logic [15:0] pc_new_r,
   output logic push_r,
   output logic [15:0] push_data_r,
   output logic pop_r,
   output logic flags_wr_r,
   output logic [7:0] flags_new_r
);
   import bsc_pkg::*;

   bsc_state_t state_r;
   logic [CYC_W-1:0] cnt_r;
   logic accept;
   // results computed at accept time, held until the op's last cycle
   logic [CYC_W-1:0] cyc_nxt;
   logic [PC_W-1:0] pc_nxt;
   logic push_nxt;
   logic [PC_W-1:0] push_data_nxt;
   logic pop_nxt;
   logic fwr_nxt;
   logic [7:0] flags_nxt;
   logic [PC_W-1:0] pc_hold_r;
   logic push_hold_r;
   logic [PC_W-1:0] push_data_hold_r;
   logic pop_hold_r;
   logic fwr_hold_r;
   logic [7:0] flags_hold_r;
   // comparator and condition helpers
   logic [7:0] sub_rhs;
   logic sub_cin;
   logic [8:0] sub_full;
   logic [7:0] sub_res;
   logic cond_known;
   logic [2:0] cond_sel;
   logic cond_want;
   logic cond_hit;
   logic skip_hit;
   logic [PC_W-1:0] rel_target;
   logic [PC_W-1:0] skip_target;

   assign accept = req.valid && (state_r == ST_READY);

   always_comb begin
      sub_rhs = (req.op == OP_COMPARE_IMMEDIATE) ? req.imm : req.rr_val;
      sub_cin = (req.op == OP_COMPARE_WITH_BORROW) ? flags_in[FLAG_C] : 1'b0;
      sub_full = {1'b0, req.rd_val} - {1'b0, sub_rhs} - {8'h00, sub_cin};
      sub_res = sub_full[7:0];
   end

   // map every branch but the two signed ones onto a flag index and the level that takes it
   always_comb begin
      cond_known = 1'b1;
      cond_sel = req.flag_sel;
      cond_want = 1'b1;
      case (req.op)
         OP_BRANCH_FLAG_SET: cond_want = 1'b1;
         OP_BRANCH_FLAG_CLEAR: cond_want = 1'b0;
         OP_BRANCH_EQUAL: begin
            cond_sel = FLAG_Z;
            cond_want = 1'b1;
         end
         OP_BRANCH_NOT_EQUAL: begin
            cond_sel = FLAG_Z;
            cond_want = 1'b0;
         end
         OP_BRANCH_CARRY_SET, OP_BRANCH_UNSIGNED_LOWER: begin
            cond_sel = FLAG_C;
            cond_want = 1'b1;
         end
         OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: begin
            cond_sel = FLAG_C;
            cond_want = 1'b0;
         end
         OP_BRANCH_NEGATIVE: begin
            cond_sel = FLAG_N;
            cond_want = 1'b1;
         end
         OP_BRANCH_POSITIVE: begin
            cond_sel = FLAG_N;
            cond_want = 1'b0;
         end
         OP_BRANCH_HALF_CARRY_SET: begin
            cond_sel = FLAG_H;
            cond_want = 1'b1;
         end
         OP_BRANCH_HALF_CARRY_CLEAR: begin
            cond_sel = FLAG_H;
            cond_want = 1'b0;
         end
         OP_BRANCH_TRANSFER_SET: begin
            cond_sel = FLAG_T;
            cond_want = 1'b1;
         end
         OP_BRANCH_TRANSFER_CLEAR: begin
            cond_sel = FLAG_T;
            cond_want = 1'b0;
         end
         OP_BRANCH_OVERFLOW_SET: begin
            cond_sel = FLAG_V;
            cond_want = 1'b1;
         end
         OP_BRANCH_OVERFLOW_CLEAR: begin
            cond_sel = FLAG_V;
            cond_want = 1'b0;
         end
         // signed tests use N xor V, handled below
         OP_BRANCH_SIGNED_GE: cond_want = 1'b0;
         OP_BRANCH_SIGNED_LESS: cond_want = 1'b1;
         default: cond_known = 1'b0;
      endcase
   end

   always_comb begin
      if ((req.op == OP_BRANCH_SIGNED_GE) || (req.op == OP_BRANCH_SIGNED_LESS)) begin
         cond_hit = ((flags_in[FLAG_N] ^ flags_in[FLAG_V]) == cond_want);
      end else begin
         cond_hit = cond_known && (flags_in[cond_sel] == cond_want);
      end
   end

   always_comb begin
      case (req.op)
         OP_COMPARE_SKIP_EQUAL: skip_hit = (req.rd_val == req.rr_val);
         OP_SKIP_REG_BIT_CLEAR: skip_hit = ~req.rr_val[req.bit_sel];
         OP_SKIP_REG_BIT_SET: skip_hit = req.rr_val[req.bit_sel];
         OP_SKIP_IO_BIT_CLEAR: skip_hit = ~req.io_val[req.bit_sel];
         OP_SKIP_IO_BIT_SET: skip_hit = req.io_val[req.bit_sel];
         default: skip_hit = 1'b0;
      endcase
   end

   // pc + k + 1 with k sign extended; wraps at the pc width like the real counter
   assign rel_target = req.pc + {{(PC_W-K_W){req.offset[K_W-1]}}, req.offset} + PC_STEP_ONE;
   assign skip_target = req.pc + (req.next_two_word ? PC_STEP_THREE : PC_STEP_TWO);

   always_comb begin
      cyc_nxt = CYC_SHORT;
      pc_nxt = req.pc + PC_STEP_ONE;
      push_nxt = 1'b0;
      push_data_nxt = req.pc + PC_STEP_ONE;
      pop_nxt = 1'b0;
      fwr_nxt = 1'b0;
      flags_nxt = flags_in;
      case (req.op)
         OP_POINTER_SUBROUTINE_JUMP: begin
            cyc_nxt = CYC_PTR_CALL;
            pc_nxt = zptr;
            push_nxt = 1'b1;
         end
         OP_DIRECT_SUBROUTINE_JUMP: begin
            // the target word follows the opcode, so return past both words
            cyc_nxt = CYC_CALL_RET;
            pc_nxt = req.target;
            push_nxt = 1'b1;
            push_data_nxt = req.pc + PC_STEP_TWO;
         end
         OP_SUBROUTINE_EXIT: begin
            cyc_nxt = CYC_CALL_RET;
            pc_nxt = stack_top;
            pop_nxt = 1'b1;
         end
         OP_INTERRUPT_EXIT: begin
            cyc_nxt = CYC_CALL_RET;
            pc_nxt = stack_top;
            pop_nxt = 1'b1;
            fwr_nxt = 1'b1;
            flags_nxt[FLAG_I] = 1'b1;
         end
         OP_COMPARE_REGISTERS, OP_COMPARE_WITH_BORROW, OP_COMPARE_IMMEDIATE: begin
            fwr_nxt = 1'b1;
            flags_nxt[FLAG_C] = sub_full[8];
            flags_nxt[FLAG_N] = sub_res[7];
            flags_nxt[FLAG_V] = (req.rd_val[7] & ~sub_rhs[7] & ~sub_res[7]) |
                                (~req.rd_val[7] & sub_rhs[7] & sub_res[7]);
            flags_nxt[FLAG_H] = (~req.rd_val[3] & sub_rhs[3]) | (sub_rhs[3] & sub_res[3]) |
                                (sub_res[3] & ~req.rd_val[3]);
            // the borrow form keeps Z only if the earlier bytes were zero too
            if (req.op == OP_COMPARE_WITH_BORROW) begin
               flags_nxt[FLAG_Z] = (sub_res == 8'h00) & flags_in[FLAG_Z];
            end else begin
               flags_nxt[FLAG_Z] = (sub_res == 8'h00);
            end
         end
         OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
         OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET: begin
            if (skip_hit) begin
               cyc_nxt = req.next_two_word ? CYC_SKIP_LONG : CYC_TAKEN;
               pc_nxt = skip_target;
            end
         end
         default: begin
            if (cond_hit) begin
               cyc_nxt = CYC_TAKEN;
               pc_nxt = rel_target;
            end
         end
      endcase
   end

   // sequencing: ready drops for multi-cycle ops, done marks the last cycle
   always_ff @(posedge clock) begin
      if (srst) begin
         state_r <= ST_READY;
         cnt_r <= '0;
         req_ready_r <= 1'b1;
      end else begin
         case (state_r)
            ST_READY: begin
               if (accept && (cyc_nxt != CYC_SHORT)) begin
                  state_r <= ST_BUSY;
                  cnt_r <= cyc_nxt - CYC_SHORT;
                  req_ready_r <= 1'b0;
               end
            end
            ST_BUSY: begin
               cnt_r <= cnt_r - CYC_SHORT;
               if (cnt_r == CYC_SHORT) begin
                  state_r <= ST_READY;
                  req_ready_r <= 1'b1;
               end
            end
            default: begin
               state_r <= ST_READY;
               req_ready_r <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         pc_hold_r <= PC_RESET;
         push_hold_r <= 1'b0;
         push_data_hold_r <= PC_RESET;
         pop_hold_r <= 1'b0;
         fwr_hold_r <= 1'b0;
         flags_hold_r <= FLAGS_RESET;
      end else if (accept) begin
         pc_hold_r <= pc_nxt;
         push_hold_r <= push_nxt;
         push_data_hold_r <= push_data_nxt;
         pop_hold_r <= pop_nxt;
         fwr_hold_r <= fwr_nxt;
         flags_hold_r <= flags_nxt;
      end
   end

   // results appear together with done; a one-cycle op shows them the cycle after accept
   always_ff @(posedge clock) begin
      if (srst) begin
         done_r <= 1'b0;
         pc_wr_r <= 1'b0;
         pc_new_r <= PC_RESET;
         push_r <= 1'b0;
         push_data_r <= PC_RESET;
         pop_r <= 1'b0;
         flags_wr_r <= 1'b0;
         flags_new_r <= FLAGS_RESET;
      end else if (accept && (state_r == ST_READY) && (cyc_nxt == CYC_SHORT)) begin
         done_r <= 1'b1;
         pc_wr_r <= 1'b1;
         pc_new_r <= pc_nxt;
         push_r <= push_nxt;
         push_data_r <= push_data_nxt;
         pop_r <= pop_nxt;
         flags_wr_r <= fwr_nxt;
         flags_new_r <= flags_nxt;
      end else if ((state_r == ST_BUSY) && (cnt_r == CYC_SHORT)) begin
         done_r <= 1'b1;
         pc_wr_r <= 1'b1;
         pc_new_r <= pc_hold_r;
         push_r <= push_hold_r;
         push_data_r <= push_data_hold_r;
         pop_r <= pop_hold_r;
         flags_wr_r <= fwr_hold_r;
         flags_new_r <= flags_hold_r;
      end else begin
         done_r <= 1'b0;
         pc_wr_r <= 1'b0;
         push_r <= 1'b0;
         pop_r <= 1'b0;
         flags_wr_r <= 1'b0;
      end
   end
endmodule // bsc_unit

// *** testbench/bsc_unit_props.sv ***
// port assertions for the branch, skip and compare unit
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module bsc_unit_props (
   input wire logic clock,
   input wire logic srst,
   input bsc_pkg::bsc_req_t req,
   input wire logic [7:0] flags_in,
   input wire logic [15:0] zptr,
   input wire logic [15:0] stack_top,
   input wire logic req_ready_r,
   input wire logic done_r,
   input wire logic pc_wr_r,
   input wire logic [15:0] pc_new_r,
   input wire logic push_r,
   input wire logic [15:0] push_data_r,
   input wire logic pop_r,
   input wire logic flags_wr_r,
   input wire logic [7:0] flags_new_r
);
   import bsc_pkg::*;
   logic take;
   logic [15:0] tgt;
   bsc_op_t op_r;
   assign take = req.valid && req_ready_r;
   assign tgt = req.pc + {{9{req.offset[6]}}, req.offset} + 16'h0001;
   // op_r still holds the finishing op at the edge where done is seen
   always_ff @(posedge clock) begin
      if (take) begin
         op_r <= req.op;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   a_ptr_call_result: assert property (take && req.op == OP_POINTER_SUBROUTINE_JUMP |->
      ##1 !done_r ##1 !done_r ##1 done_r && push_r && pc_new_r == $past(zptr, 3)
      && push_data_r == $past(req.pc, 3) + 16'h0001) else $error("pointer call result wrong");
   a_call_ret_four: assert property (take && req.op inside {OP_DIRECT_SUBROUTINE_JUMP, OP_SUBROUTINE_EXIT}
      |-> ##1 (!done_r)[*3] ##1 done_r) else $error("call or return length wrong");
   a_iret_sets_i: assert property (take && req.op == OP_INTERRUPT_EXIT |-> ##4 done_r && pop_r && flags_wr_r
      && flags_new_r == ($past(flags_in, 4) | 8'h80) && pc_new_r == $past(stack_top, 4))
      else $error("interrupt exit wrong");
   a_cmp_zero_carry: assert property (take && req.op == OP_COMPARE_REGISTERS |-> ##1 done_r && flags_wr_r
      && flags_new_r[1] == ($past(req.rd_val) == $past(req.rr_val))
      && flags_new_r[0] == ($past(req.rd_val) < $past(req.rr_val))) else $error("compare flags wrong");
   a_flag_set_jump: assert property (take && req.op == OP_BRANCH_FLAG_SET && flags_in[req.flag_sel]
      |-> ##1 !done_r ##1 done_r && pc_new_r == $past(tgt, 2)) else $error("flag set branch wrong");
   a_flag_clear_stay: assert property (take && req.op == OP_BRANCH_FLAG_CLEAR && flags_in[req.flag_sel]
      |-> ##1 done_r && pc_new_r == $past(req.pc) + 16'h0001) else $error("untaken branch wrong");
   a_not_equal_jump: assert property (take && req.op == OP_BRANCH_NOT_EQUAL && !flags_in[1]
      |-> ##1 !done_r ##1 done_r && pc_new_r == $past(tgt, 2)) else $error("not equal branch wrong");
   a_io_skip_long: assert property (take && req.op == OP_SKIP_IO_BIT_SET && req.io_val[req.bit_sel]
      && req.next_two_word |-> ##1 !done_r ##1 !done_r ##1 done_r && pc_new_r == $past(req.pc, 3) + 16'h0003)
      else $error("io skip wrong");
   a_reg_skip_short: assert property (take && req.op == OP_SKIP_REG_BIT_CLEAR && !req.rr_val[req.bit_sel]
      && !req.next_two_word |-> ##1 !done_r ##1 done_r && pc_new_r == $past(req.pc, 2) + 16'h0002)
      else $error("register skip wrong");
   a_flags_kept: assert property (done_r && !(op_r inside {OP_COMPARE_REGISTERS, OP_COMPARE_WITH_BORROW,
      OP_COMPARE_IMMEDIATE, OP_INTERRUPT_EXIT}) |-> !flags_wr_r) else $error("flags written wrongly");
   a_ready_tracks_done: assert property (take |-> ##1 (req_ready_r == done_r))
      else $error("ready level wrong after take");
   c_iret: cover property (take && req.op == OP_INTERRUPT_EXIT);
   c_push: cover property (done_r && push_r);
   c_flags: cover property (done_r && flags_wr_r);
endmodule // bsc_unit_props

// *** testbench/testbench.sv ***
// self-checking bench for the branch, skip and compare unit
// assumes the unit takes a request at an edge where valid and ready are high
`timescale 1ns/1ps
module testbench;
   import bsc_pkg::*;
   localparam logic [39:0] CMP_A = 40'h05_0100_8010;
   localparam logic [39:0] CMP_B = 40'h07_0000_0110;
   localparam logic [39:0] CMP_F = 40'hc0_0103_0010;
   localparam logic [55:0] SKIP_V = 56'h02_0808_80fe_3c3c;
   logic clock, srst, req_ready_r, done_r, pc_wr_r, push_r, pop_r, flags_wr_r;
   bsc_req_t req, r;
   logic [7:0] flags_in, flags_new_r;
   logic [15:0] zptr, stack_top, pc_new_r, push_data_r;
   int mismatches, checked, cyc;
   bsc_unit bsc_unit_i (.clock(clock), .srst(srst), .req(req), .flags_in(flags_in), .zptr(zptr),
      .stack_top(stack_top), .req_ready_r(req_ready_r), .done_r(done_r), .pc_wr_r(pc_wr_r), .pc_new_r(pc_new_r),
      .push_r(push_r), .push_data_r(push_data_r), .pop_r(pop_r), .flags_wr_r(flags_wr_r), .flags_new_r(flags_new_r));
   initial begin
      clock = 0;
      forever #5 clock = ~clock;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // valid drops right after the taking edge so the op is never taken twice
   task automatic issue();
      r.valid = 1;
      req = r;
      while (req_ready_r !== 1'b1) @(posedge clock) #1;
      @(posedge clock) #1;
      req.valid = 0;
      cyc = 1;
      while (done_r !== 1'b1 && cyc < 9) begin
         @(posedge clock) #1;
         cyc++;
      end
   endtask
   task automatic judge(input int n, input logic [15:0] pc, input logic [2:0] pl);
      check(16'(cyc), 16'(n));
      check(pc_new_r, pc);
      check({13'h0, push_r, pop_r, flags_wr_r}, {13'h0, pl});
      check({15'h0, pc_wr_r}, 16'h0001);
      check({15'h0, req_ready_r}, 16'h0001);
   endtask
   function automatic logic [7:0] cmp_flags(input logic [7:0] a, b, f, input logic wc);
      logic [8:0] d;
      logic [4:0] h;
      logic [7:0] o;
      d = {1'b0, a} - {1'b0, b} - 9'(wc & f[0]);
      h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(wc & f[0]);
      o = f;
      o[0] = d[8];
      o[1] = (d[7:0] == 8'h00) & (f[1] | !wc);
      o[2] = d[7];
      o[3] = (a[7] ^ b[7]) & (a[7] ^ d[7]);
      o[5] = h[4];
      return o;
   endfunction
   // branch ops in code order from the flag-set branch; pairs share one flag test
   function automatic logic br_taken(input int i, input logic [7:0] f, input logic [2:0] s);
      logic v;
      case (i / 2)
         0: v = f[s];
         1: v = f[1];
         2, 3: v = f[0];
         4: v = f[2];
         5: v = f[2] ^ f[3];
         6: v = f[5];
         7: v = f[6];
         default: v = f[3];
      endcase
      return v ^ ((i % 2 == 1) ^ (i == 6 || i == 7 || i == 10 || i == 11));
   endfunction
   task automatic t_flow();
      r = '0;
      r.pc = 16'h0100;
      r.target = 16'h0a00;
      zptr = 16'h1234;
      stack_top = 16'h0456;
      flags_in = 8'h15;
      r.op = OP_POINTER_SUBROUTINE_JUMP;
      issue();
      judge(3, 16'h1234, 3'b100);
      check(push_data_r, 16'h0101);
      r.op = OP_DIRECT_SUBROUTINE_JUMP;
      issue();
      judge(4, 16'h0a00, 3'b100);
      check(push_data_r, 16'h0102);
      r.op = OP_SUBROUTINE_EXIT;
      issue();
      judge(4, 16'h0456, 3'b010);
      r.op = OP_INTERRUPT_EXIT;
      issue();
      judge(4, 16'h0456, 3'b011);
      check({8'h00, flags_new_r}, 16'h0095);
      $display("flow test done");
   endtask
   task automatic t_compare();
      logic [7:0] b;
      r = '0;
      r.pc = 16'h00ff;
      for (int i = 0; i < 5; i++) begin
         b = CMP_B[8*i +: 8];
         r.op = i < 2 ? OP_COMPARE_REGISTERS : i < 4 ? OP_COMPARE_WITH_BORROW : OP_COMPARE_IMMEDIATE;
         r.rd_val = CMP_A[8*i +: 8];
         r.rr_val = i == 4 ? 8'h55 : b;
         r.imm = i == 4 ? b : 8'h55;
         flags_in = CMP_F[8*i +: 8];
         issue();
         judge(1, 16'h0100, 3'b001);
         check({8'h00, flags_new_r}, {8'h00, cmp_flags(r.rd_val, b, flags_in, i == 2 || i == 3)});
      end
      $display("compare test done");
   endtask
   task automatic t_skip();
      bsc_op_t ops[7] = '{OP_COMPARE_SKIP_EQUAL, OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR,
         OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET, OP_SKIP_REG_BIT_CLEAR};
      int n[7] = '{2, 1, 3, 2, 1, 3, 2};
      int bs[7] = '{0, 0, 0, 7, 3, 3, 1};
      logic [7:0] v;
      r = '0;
      r.pc = 16'h0200;
      for (int i = 0; i < 7; i++) begin
         v = SKIP_V[8*i +: 8];
         r.op = ops[i];
         r.bit_sel = 3'(bs[i]);
         r.next_two_word = n[i] == 3;
         r.rd_val = v;
         r.rr_val = i == 1 ? 8'h3d : i < 4 ? v : ~v;
         r.io_val = i < 4 ? ~v : v;
         issue();
         judge(n[i], r.pc + 16'(n[i]), 3'b000);
      end
      $display("skip test done");
   endtask
   task automatic t_branch();
      logic [7:0] fl[4] = '{8'h00, 8'hff, 8'h04, 8'h08};
      logic tk;
      logic [15:0] pcx;
      r = '0;
      r.pc = 16'h0010;
      for (int i = 0; i < 18; i++) begin
         for (int j = 0; j < 4; j++) begin
            r.op = bsc_op_t'(5'(i + 12));
            r.flag_sel = 3'(i + j);
            r.offset = j[0] ? 7'h40 : 7'h3f;
            flags_in = fl[j];
            tk = br_taken(i, fl[j], r.flag_sel);
            issue();
            pcx = r.pc + 16'h0001 + (tk ? {{9{r.offset[6]}}, r.offset} : 16'h0000);
            judge(tk ? 2 : 1, pcx, 3'b000);
         end
      end
      $display("branch test done");
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      srst = 1;
      req = '0;
      r = '0;
      flags_in = 8'h00;
      zptr = 16'h0000;
      stack_top = 16'h0000;
      repeat (4) @(posedge clock);
      #1 srst = 0;
      t_flow();
      t_compare();
      t_skip();
      t_branch();
      report_and_stop();
   end
   // 88 ops of at most 4 cycles each, so 5000 cycles is ample
   initial begin
      #50000;
      mismatches++;
      report_and_stop();
   end
endmodule // testbench
bind bsc_unit bsc_unit_props bsc_unit_props_i (.clock(clock), .srst(srst), .req(req), .flags_in(flags_in),
   .zptr(zptr), .stack_top(stack_top), .req_ready_r(req_ready_r), .done_r(done_r), .pc_wr_r(pc_wr_r),
   .pc_new_r(pc_new_r), .push_r(push_r), .push_data_r(push_data_r), .pop_r(pop_r), .flags_wr_r(flags_wr_r),
   .flags_new_r(flags_new_r));
